// [logic/pde_pkg.sv]
// Constants and carrier types for the port D / port E pad function select.
// Assumes a single 200 MHz core clock and a synchronous active-low reset.
`default_nettype none
package pde_pkg;
    localparam int PORT_D_W = 8;
    localparam int PORT_E_W = 2;
    localparam int CS_PINS = 6;
    localparam int SER1_TX_BIT = 6;
    localparam int SER1_RX_BIT = 7;
    localparam int SER0_TX_BIT = 0;
    localparam int SER0_RX_BIT = 1;
    // Function select: 1 = peripheral, 0 = general-purpose I/O
    localparam logic [7:0] PORT_D_FUNC_RST = 8'hc0;
    localparam logic [1:0] PORT_E_FUNC_RST = 2'h3;
    localparam logic [7:0] PORT_D_DIR_RST = 8'h00;
    localparam logic [1:0] PORT_E_DIR_RST = 2'h0;
    localparam logic [7:0] PORT_D_OUT_RST = 8'h00;
    localparam logic [1:0] PORT_E_OUT_RST = 2'h0;
    localparam logic [7:0] PORT_D_PULL_RST = 8'hff;
    localparam logic [1:0] PORT_E_PULL_RST = 2'h3;
    localparam logic BUS_DRIVE_RST = 1'b0;
    localparam logic DBG_PULL_OFF_RST = 1'b0;
    localparam logic CS01_STROBE_RST = 1'b1;

    typedef struct packed {
        logic [7:0] portDFunc;
        logic [7:0] portDDir;
        logic [7:0] portDOut;
        logic [7:0] portDPull;
        logic [1:0] portEFunc;
        logic [1:0] portEDir;
        logic [1:0] portEOut;
        logic [1:0] portEPull;
        logic busDriveBit;
        logic dbgPullOff;
    } pde_cfg_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pull;
    } pde_pad_d_t;

    typedef struct packed {
        logic [1:0] out;
        logic [1:0] oe;
        logic [1:0] pull;
    } pde_pad_e_t;

    typedef struct packed {
        logic progOut;
        logic progOe;
        logic dataOut;
        logic dataOe;
    } pde_strobe_t;

    typedef struct packed {
        logic tdoOut;
        logic tdoOe;
        logic tmsPull;
        logic tdiPull;
        logic tckPullDown;
    } pde_dbg_t;
endpackage
`default_nettype wire

// [logic/pde_pin_select.sv]
// Pad function select and pull control for port D, port E and debug pads.
// Assumes config is loaded by a one-cycle strobe and all inputs are
// synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module pde_pin_select (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Configuration load
    input wire logic cfgLoad,
    input wire pde_pkg::pde_cfg_t cfgIn,
    output pde_pkg::pde_cfg_t cfgOut,
    // External memory interface side, selects active low
    input wire logic [7:0] chipSelectN,
    input wire logic busActive,
    // Serial channel side
    input wire logic serial0Transmit,
    input wire logic serial1Transmit,
    output logic serial0Receive,
    output logic serial1Receive,
    // GPIO input values
    output logic [7:0] portDIn,
    output logic [1:0] portEIn,
    // Pads
    input wire logic [7:0] padDIn,
    input wire logic [1:0] padEIn,
    output pde_pkg::pde_pad_d_t padD,
    output pde_pkg::pde_pad_e_t padE,
    output pde_pkg::pde_strobe_t strobePads,
    // Test controller and debug pads
    input wire logic tapShiftIr,
    input wire logic tapShiftDr,
    input wire logic tdoData,
    output pde_pkg::pde_dbg_t dbgPads
);
    pde_pkg::pde_cfg_t cfg_r, cfg_nxt;
    pde_pkg::pde_pad_d_t padD_r, padD_nxt;
    pde_pkg::pde_pad_e_t padE_r, padE_nxt;
    pde_pkg::pde_strobe_t strobe_r, strobe_nxt;
    pde_pkg::pde_dbg_t dbg_r, dbg_nxt;
    logic [7:0] portDIn_r, portDIn_nxt;
    logic [1:0] portEIn_r, portEIn_nxt;
    logic ser0Rx_r, ser0Rx_nxt, ser1Rx_r, ser1Rx_nxt;
    logic csDrive;
    // Peripheral-side pad drive per port D pin, fixed by pin position
    wire logic [7:0] dPeriOut, dPeriOe;

    ////////////////////////////////////////////////////////////////////////
    // Configuration state
    always_comb begin
        cfg_nxt = cfg_r;
        if (cfgLoad) begin
            cfg_nxt = cfgIn;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cfg_r.portDFunc <= pde_pkg::PORT_D_FUNC_RST;
            cfg_r.portDDir <= pde_pkg::PORT_D_DIR_RST;
            cfg_r.portDOut <= pde_pkg::PORT_D_OUT_RST;
            cfg_r.portDPull <= pde_pkg::PORT_D_PULL_RST;
            cfg_r.portEFunc <= pde_pkg::PORT_E_FUNC_RST;
            cfg_r.portEDir <= pde_pkg::PORT_E_DIR_RST;
            cfg_r.portEOut <= pde_pkg::PORT_E_OUT_RST;
            cfg_r.portEPull <= pde_pkg::PORT_E_PULL_RST;
            cfg_r.busDriveBit <= pde_pkg::BUS_DRIVE_RST;
            cfg_r.dbgPullOff <= pde_pkg::DBG_PULL_OFF_RST;
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Port D pads
    assign csDrive = cfg_r.busDriveBit | busActive;

    for (genvar i = 0; i < pde_pkg::PORT_D_W; i++) begin : g_portD
        // Chosen at elaboration so no select index runs out of range
        if (i < pde_pkg::CS_PINS) begin : g_cs
            assign dPeriOut[i] = chipSelectN[i + 2];
            assign dPeriOe[i] = csDrive;
        end else if (i == pde_pkg::SER1_TX_BIT) begin : g_tx
            assign dPeriOut[i] = serial1Transmit;
            assign dPeriOe[i] = 1'b1;
        end else begin : g_rx
            assign dPeriOut[i] = 1'b0;
            assign dPeriOe[i] = 1'b0;
        end
        always_comb begin
            padD_nxt.pull[i] = cfg_r.portDPull[i];
            portDIn_nxt[i] = padDIn[i];
            if (!cfg_r.portDFunc[i]) begin
                padD_nxt.out[i] = cfg_r.portDOut[i];
                padD_nxt.oe[i] = cfg_r.portDDir[i];
            end else begin
                padD_nxt.out[i] = dPeriOut[i];
                padD_nxt.oe[i] = dPeriOe[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Port E pads and serial receive paths
    for (genvar j = 0; j < pde_pkg::PORT_E_W; j++) begin : g_portE
        always_comb begin
            padE_nxt.pull[j] = cfg_r.portEPull[j];
            portEIn_nxt[j] = padEIn[j];
            if (!cfg_r.portEFunc[j]) begin
                padE_nxt.out[j] = cfg_r.portEOut[j];
                padE_nxt.oe[j] = cfg_r.portEDir[j];
            end else if (j == pde_pkg::SER0_TX_BIT) begin
                padE_nxt.out[j] = serial0Transmit;
                padE_nxt.oe[j] = 1'b1;
            end else begin
                padE_nxt.out[j] = 1'b0;
                padE_nxt.oe[j] = 1'b0;
            end
        end
    end

    // Receivers idle high when their pin is taken for GPIO
    always_comb begin
        ser0Rx_nxt = cfg_r.portEFunc[pde_pkg::SER0_RX_BIT] ?
            padEIn[pde_pkg::SER0_RX_BIT] : 1'b1;
        ser1Rx_nxt = cfg_r.portDFunc[pde_pkg::SER1_RX_BIT] ?
            padDIn[pde_pkg::SER1_RX_BIT] : 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory strobes and debug pads
    always_comb begin
        strobe_nxt.progOut = chipSelectN[0];
        strobe_nxt.progOe = csDrive;
        strobe_nxt.dataOut = chipSelectN[1];
        strobe_nxt.dataOe = csDrive;
        dbg_nxt.tdoOut = tdoData;
        dbg_nxt.tdoOe = tapShiftIr | tapShiftDr;
        dbg_nxt.tmsPull = ~cfg_r.dbgPullOff;
        dbg_nxt.tdiPull = ~cfg_r.dbgPullOff;
        dbg_nxt.tckPullDown = 1'b1;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            padD_r.out <= pde_pkg::PORT_D_OUT_RST;
            padD_r.oe <= pde_pkg::PORT_D_DIR_RST;
            padD_r.pull <= pde_pkg::PORT_D_PULL_RST;
            padE_r.out <= pde_pkg::PORT_E_OUT_RST;
            padE_r.oe <= pde_pkg::PORT_E_DIR_RST;
            padE_r.pull <= pde_pkg::PORT_E_PULL_RST;
            strobe_r <= '{progOut: 1'b1, progOe: 1'b0, dataOut: 1'b1, dataOe: 1'b0};
            dbg_r <= '{tdoOut: 1'b0, tdoOe: 1'b0, tmsPull: 1'b1, tdiPull: 1'b1,
                       tckPullDown: 1'b1};
            portDIn_r <= 8'h00;
            portEIn_r <= 2'h0;
            ser0Rx_r <= 1'b1;
            ser1Rx_r <= 1'b1;
        end else begin
            padD_r <= padD_nxt;
            padE_r <= padE_nxt;
            strobe_r <= strobe_nxt;
            dbg_r <= dbg_nxt;
            portDIn_r <= portDIn_nxt;
            portEIn_r <= portEIn_nxt;
            ser0Rx_r <= ser0Rx_nxt;
            ser1Rx_r <= ser1Rx_nxt;
        end
    end

    assign cfgOut = cfg_r;
    assign padD = padD_r;
    assign padE = padE_r;
    assign strobePads = strobe_r;
    assign dbgPads = dbg_r;
    assign portDIn = portDIn_r;
    assign portEIn = portEIn_r;
    assign serial0Receive = ser0Rx_r;
    assign serial1Receive = ser1Rx_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    chk_gpio_dir: assert property (
        !$past(cfg_r.portDFunc[0]) |-> padD_r.oe[0] == $past(cfg_r.portDDir[0]))
        else $error("GPIO enable does not follow direction bit");
    chk_cs_route: assert property (
        $past(cfg_r.portDFunc[5]) |-> padD_r.out[5] == $past(chipSelectN[7]))
        else $error("Chip select 7 not routed to port D pin 5");
    chk_cs_float: assert property (
        $past(cfg_r.portDFunc[2] && !cfg_r.busDriveBit && !busActive) |-> !padD_r.oe[2])
        else $error("Chip select driven while bus idle without drive bit");
    chk_reset_gpio: assert property (
        $rose(rst_n) |-> padD_r.oe[5:0] == 6'h00 && padD_r.pull == 8'hff
            && cfg_r.portDFunc[5:0] == 6'h00)
        else $error("Port D not GPIO input with pull-ups after reset");
    chk_pull_d: assert property (
        padD_r.pull == $past(cfg_r.portDPull))
        else $error("Port D pull-up does not follow enable bits");
    chk_tx_default: assert property (
        $rose(rst_n) ##1 !$past(cfgLoad) |-> padD_r.oe[6] && padE_r.oe[0])
        else $error("Serial transmit pins not driven after reset");
    chk_rx1_path: assert property (
        $past(rst_n && cfg_r.portDFunc[7])
            |-> serial1Receive == $past(padDIn[7]) && !padD_r.oe[7])
        else $error("Serial one receive path wrong");
    chk_pull_e: assert property (
        padE_r.pull[1] == $past(cfg_r.portEPull[1]))
        else $error("Port E pin 1 pull-up wrong");
    chk_dbg_pull: assert property (
        dbg_r.tmsPull == dbg_r.tdiPull && dbg_r.tmsPull == !$past(cfg_r.dbgPullOff))
        else $error("Debug pull-ups not under disable bit");
    chk_tck_pulldown: assert property (dbg_r.tckPullDown)
        else $error("Test clock pull-down missing");
    chk_tdo_enable: assert property (
        $past(rst_n) |-> dbg_r.tdoOe == $past(tapShiftIr || tapShiftDr))
        else $error("Test data output enable outside shift states");
    chk_strobe_route: assert property (
        $past(rst_n) |-> strobePads.progOut == $past(chipSelectN[0])
            && strobePads.dataOe == $past(csDrive))
        else $error("Memory strobe wrong");

    cov_cs_float: cover property ($past(cfg_r.portDFunc[0]) && !padD_r.oe[0]);
    cov_gpio_out: cover property (!$past(cfg_r.portDFunc[3]) && padD_r.oe[3]);
    cov_tdo_shift: cover property ($rose(dbg_r.tdoOe));
    cov_dbg_off: cover property (!dbg_r.tmsPull);
endmodule
`default_nettype wire

// [testbench/pde_pad_model.sv]
// Pad model: resolves each pad level from the block, an outside driver and pulls.
// Assumes pad controls are registered on core_clk.
`timescale 1ns/1ps
`default_nettype none
module pde_pad_model (
    // Clock
    input wire logic core_clk,
    // Pad controls from the block
    input wire pde_pkg::pde_pad_d_t padD,
    input wire pde_pkg::pde_pad_e_t padE,
    // Outside world
    input wire logic [7:0] extD,
    input wire logic [1:0] extE,
    input wire logic extOn,
    // Resolved levels
    output logic [7:0] padDIn,
    output logic [1:0] padEIn
);
    logic wander_r = 1'b0;
    // Undriven, unpulled pads wander
    always @(posedge core_clk) begin
        wander_r <= ~wander_r;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            padDIn[i] = padD.oe[i] ? padD.out[i] : extOn ? extD[i] : padD.pull[i] | wander_r;
        end
        for (int i = 0; i < 2; i++) begin
            padEIn[i] = padE.oe[i] ? padE.out[i] : extOn ? extE[i] : padE.pull[i] | wander_r;
        end
    end
endmodule
`default_nettype wire

// [testbench/test_port_d_e_pin_function_select.sv]
// Self-checking bench: random config and live inputs, reference model per cycle.
// Assumes the pad model closes the loop from pad controls to pad inputs.
`timescale 1ns/1ps
`default_nettype none
module test_port_d_e_pin_function_select;
    logic core_clk = 1'b0, rst_n = 1'b0, cfgLoad = 1'b0, extOn = 1'b0, live = 1'b0;
    logic busActive = 1'b0, serial0Transmit = 1'b0, serial1Transmit = 1'b0;
    logic tapShiftIr = 1'b0, tapShiftDr = 1'b0, tdoData = 1'b0;
    logic serial0Receive, serial1Receive;
    logic [7:0] chipSelectN = 8'hff, extD = 8'h00, portDIn, padDIn, eDIn, mD;
    logic [1:0] extE = 2'h0, portEIn, padEIn, eEIn, eRx, mE;
    pde_pkg::pde_cfg_t cfgIn = '0, cfgOut, m;
    pde_pkg::pde_pad_d_t padD, eD;
    pde_pkg::pde_pad_e_t padE, eE;
    pde_pkg::pde_strobe_t strobePads, eS;
    pde_pkg::pde_dbg_t dbgPads, eG;
    integer seed = 32'h94ef, err_total = 0, samples_checked = 0;

    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    pde_pin_select i_dut (.core_clk(core_clk), .rst_n(rst_n), .cfgLoad(cfgLoad),
        .cfgIn(cfgIn), .cfgOut(cfgOut), .chipSelectN(chipSelectN), .busActive(busActive),
        .serial0Transmit(serial0Transmit), .serial1Transmit(serial1Transmit),
        .serial0Receive(serial0Receive), .serial1Receive(serial1Receive),
        .portDIn(portDIn), .portEIn(portEIn), .padDIn(padDIn), .padEIn(padEIn),
        .padD(padD), .padE(padE), .strobePads(strobePads), .tapShiftIr(tapShiftIr),
        .tapShiftDr(tapShiftDr), .tdoData(tdoData), .dbgPads(dbgPads));

    pde_pad_model i_pads (.core_clk(core_clk), .padD(padD), .padE(padE), .extD(extD),
        .extE(extE), .extOn(extOn), .padDIn(padDIn), .padEIn(padEIn));

    ////////////////////////////////////////////////////////////////
    // Reference model, one step per rising edge
    always @(posedge core_clk) begin
        live = 1'b1;
        mD = 8'hff;
        mE = 2'h3;
        if (!rst_n) begin
            m = {pde_pkg::PORT_D_FUNC_RST, pde_pkg::PORT_D_DIR_RST, pde_pkg::PORT_D_OUT_RST,
                pde_pkg::PORT_D_PULL_RST, pde_pkg::PORT_E_FUNC_RST, pde_pkg::PORT_E_DIR_RST,
                pde_pkg::PORT_E_OUT_RST, pde_pkg::PORT_E_PULL_RST, pde_pkg::BUS_DRIVE_RST,
                pde_pkg::DBG_PULL_OFF_RST};
            eD = {8'h00, 8'h00, 8'hff};
            eE = {2'h0, 2'h0, 2'h3};
            eS = 4'ha;
            eG = 5'h07;
            eDIn = 8'h00;
            eEIn = 2'h0;
            eRx = 2'h3;
        end else begin
            for (int i = 0; i < 8; i++) begin
                eD.out[i] = m.portDOut[i];
                eD.oe[i] = m.portDDir[i];
                if (m.portDFunc[i]) begin
                    eD.out[i] = (i < 6) ? chipSelectN[i + 2] : serial1Transmit;
                    eD.oe[i] = (i < 6) ? (m.busDriveBit | busActive) : (i == 6);
                    mD[i] = (i != 7);
                end
            end
            eE.out = m.portEOut;
            eE.oe = m.portEDir;
            if (m.portEFunc[0]) begin
                eE.out[0] = serial0Transmit;
                eE.oe[0] = 1'b1;
            end
            if (m.portEFunc[1]) begin
                eE.oe[1] = 1'b0;
                mE[1] = 1'b0;
            end
            eD.pull = m.portDPull;
            eE.pull = m.portEPull;
            eS = {chipSelectN[0], m.busDriveBit | busActive, chipSelectN[1],
                m.busDriveBit | busActive};
            eG = {tdoData, tapShiftIr | tapShiftDr, ~m.dbgPullOff, ~m.dbgPullOff, 1'b1};
            eDIn = padDIn;
            eEIn = padEIn;
            eRx = {m.portDFunc[7] ? padDIn[7] : 1'b1, m.portEFunc[1] ? padEIn[1] : 1'b1};
            if (cfgLoad) begin
                m = cfgIn;
            end
        end
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    always @(negedge core_clk) begin
        if (live) begin
            chk(cfgOut, m);
            chk(padD.oe, eD.oe);
            chk(padD.out & mD, eD.out & mD);
            chk(padD.pull, eD.pull);
            chk({padE.oe, padE.out & mE}, {eE.oe, eE.out & mE});
            chk(padE.pull, eE.pull);
            chk(strobePads, eS);
            chk({dbgPads.tdoOe, dbgPads.tdoOut & eG.tdoOe}, {eG.tdoOe, eG.tdoOut & eG.tdoOe});
            chk(dbgPads[2:0], eG[2:0]);
            chk({serial1Receive, serial0Receive, portDIn, portEIn}, {eRx, eDIn, eEIn});
        end
    end

    ////////////////////////////////////////////////////////////////
    // Stimulus
    task automatic step(input logic ld, input logic drv);
        logic [63:0] r;
        logic [31:0] q;
        @(posedge core_clk);
        r = {$random(seed), $random(seed)};
        q = $random(seed);
        r[1] = r[1] | drv;
        cfgLoad <= ld;
        cfgIn <= r[41:0];
        chipSelectN <= r[63:56];
        busActive <= r[55];
        serial0Transmit <= r[54];
        serial1Transmit <= r[53];
        tapShiftIr <= r[52] & r[51];
        tapShiftDr <= r[52] & ~r[51];
        tdoData <= r[50];
        extD <= q[7:0];
        extE <= q[9:8];
        extOn <= q[10];
    endtask

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (400) step($random(seed) % 4 == 0, 1'b0);
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) step(1'b1, 1'b0);
        @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (400) step($random(seed) % 4 == 0, 1'b1);
        close_out();
    end
endmodule
`default_nettype wire
